//--- adc_ctrl_pkg.sv
// Package for the converter control block: register map, field layout, reset values, enums.
// Assumes a plain address/strobe register port with 8-bit data.
package adc_ctrl_pkg;
   localparam int ADDR_W = 4;
   localparam logic [3:0] OFS_STATUS_CTRL = 4'h0;
   localparam logic [3:0] OFS_CMP_CTRL = 4'h1;
   localparam logic [3:0] OFS_CONFIG = 4'h2;
   localparam logic [3:0] OFS_CMP_HIGH = 4'h3;
   localparam logic [3:0] OFS_CMP_LOW = 4'h4;
   localparam logic [3:0] OFS_RESULT_HIGH = 4'h5;
   localparam logic [3:0] OFS_RESULT_LOW = 4'h6;
   localparam logic [3:0] OFS_PIN_LOW = 4'h7;
   localparam logic [3:0] OFS_PIN_MID = 4'h8;
   localparam logic [3:0] OFS_PIN_HIGH = 4'h9;
   // Status/control: [7] complete flag, [6] irq enable, [5] continuous, [4:0] channel
   localparam int SC_FLAG_POS = 7;
   localparam int SC_IEN_POS = 6;
   localparam int SC_CONT_POS = 5;
   // Compare control: [6] hw trigger enable, [5] compare enable, [4] greater select
   localparam int CC_TRG_POS = 6;
   localparam int CC_CFE_POS = 5;
   localparam int CC_CGT_POS = 4;
   // Config: [6:5] divide, [3:2] mode, [1:0] clock source
   localparam int CF_DIV_LSB = 5;
   localparam int CF_MODE_LSB = 2;
   localparam int CF_CLK_LSB = 0;
   localparam logic [4:0] CHANNEL_OFF = 5'h1F;
   localparam logic [7:0] RST_STATUS_CTRL = 8'h1F;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [1:0] MODE_8 = 2'h0;
   localparam logic [1:0] MODE_12 = 2'h1;
   localparam logic [1:0] MODE_10 = 2'h2;
   localparam logic [1:0] SRC_BUS = 2'h0;
   localparam logic [1:0] SRC_BUS_HALF = 2'h1;
   localparam logic [1:0] SRC_ALT = 2'h2;
   localparam logic [1:0] SRC_ASYNC = 2'h3;
   localparam int ASYNC_DIV = 4;
   localparam int SAR_STEPS = 12;
   localparam int NUM_PADS = 24;
   typedef enum logic [1:0] {ST_DISABLED, ST_IDLE, ST_CONVERT} conv_state_t;
   typedef struct packed {
      logic [23:0] out_en_n;
      logic [23:0] in_en;
      logic [23:0] pull_en;
   } pad_ctrl_t;
endpackage : adc_ctrl_pkg

//--- adc_conversion_control.sv
// Control logic around a successive approximation converter: registers, clocking,
// triggering, result rounding, compare and pad control.
// Assumes the analog comparator answers each trial bit in the conversion clock step.
`timescale 1ns/1ps

// Notes on behaviour
// - Pad control bit set forces that pad's output driver off.
// - Pad control bit set disables input buffer; port read returns zero.
// - Pad control bit set disables that pad's pull-up.
// - Middle pin register bits 0..7 map to channels 8..15.
// - High pin register bits 0..7 map to channels 16..23.
// - Low pin register bit 1 is channel 1, bit 0 is channel 0.
// - Bit 0 keeps port control enabled; bit 1 disables it.
// - Converter disabled in reset and while channel select is all ones.
// - After completion the converter idles until a new start, except in continuous mode or while a held result passes compare.
// - Twelve bit internal result in 12/10 bit modes, nine in 8-bit.
// - Round to 10 bits over high/low, or 8 bits in low only.
// - After storing, set complete flag; interrupt when enable is one.
// - Automatic compare applies when compare enable set, in every mode.
// - Four clock sources by clock select; bus clock after reset.
// - Half-rate bus source gives overall divide up to sixteen.
// - Internal async clock generated here, keeps running in wait/stop3.
// - Selected source divided by 1, 2, 4 or 8 for conversion clock.
// - With hardware trigger enable one, start on each trigger rising edge.
// - Trigger edge during a conversion is ignored.
// - In continuous mode only the first trigger edge is obeyed.
// - Convert in 12, 10 or 8-bit mode; software or hardware start.
// - Mode 00 8-bit, 01 12-bit, 10 10-bit, 11 reserved.
// - Source 00 bus, 01 bus/2, 10 alternate, 11 async.
// - With compare on, flag only if result >= value (gt=1) or < (gt=0).
module adc_conversion_control
   import adc_ctrl_pkg::*;
(
   input wire logic core_clk_i, // 50 MHz core clock
   input wire logic rst_i, // Synchronous reset, active high
   input wire logic [3:0] addr_i, // Register address
   input wire logic [7:0] wdata_i, // Write data
   input wire logic wr_i, // Write strobe
   input wire logic rd_i, // Read strobe
   output logic [7:0] rdata_o, // Read data, cycle after strobe
   input wire logic alternate_clock_i, // Alternate clock, sampled
   input wire logic hw_trigger_input_i, // Asynchronous hardware trigger
   input wire logic cmp_bit_i, // Analog comparator decision
   input wire logic low_power_i, // Wait or stop3 in effect
   input wire logic [23:0] port_in_i, // Raw pad input levels
   output logic [23:0] port_read_o, // Gated pad levels to port logic
   output pad_ctrl_t pad_ctrl_o, // Per-pad driver/input/pull gates
   output logic [11:0] sar_trial_o, // Trial code to the DAC
   output logic [4:0] channel_o, // Selected analog channel
   output logic conv_active_o, // Converter powered and running
   output logic irq_o // Completion interrupt level
);
   logic [7:0] sc_reg, cc_reg, cfg_reg, cvh_reg, cvl_reg, rh_reg, rl_reg;
   logic [7:0] pin_low_reg, pin_mid_reg, pin_high_reg;
   logic [23:0] pad_disable;
   conv_state_t state_reg;
   logic [2:0] trg_sync;
   logic [2:0] alt_sync;
   logic trg_level_reg, alt_level_reg, alt_prev_reg;
   logic trg_rise;
   logic half_reg;
   logic [1:0] async_cnt_reg;
   logic src_tick;
   logic [2:0] div_cnt_reg;
   logic [2:0] div_max;
   logic ck_tick;
   logic [11:0] sar_reg;
   logic [3:0] step_reg;
   logic sw_start, cfg_write, start, disabled;
   logic hold_reg;
   logic [12:0] rounded;
   logic [11:0] result;
   logic [11:0] cmp_val;
   logic cmp_pass;
   logic done;
   logic [3:0] steps_needed;
   logic [1:0] mode;

   assign mode = cfg_reg[CF_MODE_LSB +: 2];
   assign disabled = (sc_reg[4:0] == CHANNEL_OFF);
   assign pad_disable = {pin_high_reg, pin_mid_reg, pin_low_reg};

   // Trigger synchroniser: edge taken once the last two stages agree high after low
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         trg_sync <= 3'h0;
         trg_level_reg <= 1'b0;
      end
      else
      begin
         trg_sync <= {trg_sync[1:0], hw_trigger_input_i};
         if (trg_sync[2] == trg_sync[1])
            trg_level_reg <= trg_sync[2];
      end
   end
   assign trg_rise = (trg_sync[2] == trg_sync[1]) && trg_sync[2] && !trg_level_reg;

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         alt_sync <= 3'h0;
         alt_level_reg <= 1'b0;
         alt_prev_reg <= 1'b0;
      end
      else
      begin
         alt_sync <= {alt_sync[1:0], alternate_clock_i};
         if (alt_sync[2] == alt_sync[1])
            alt_level_reg <= alt_sync[2];
         alt_prev_reg <= alt_level_reg;
      end
   end

   // Internal asynchronous source, free running so wait/stop3 do not halt it
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         half_reg <= 1'b0;
         async_cnt_reg <= 2'h0;
      end
      else
      begin
         half_reg <= !half_reg;
         async_cnt_reg <= async_cnt_reg + 2'h1;
      end
   end

   always_comb
   begin
      case (cfg_reg[CF_CLK_LSB +: 2])
         SRC_BUS: src_tick = 1'b1;
         SRC_BUS_HALF: src_tick = half_reg;
         SRC_ALT: src_tick = alt_level_reg && !alt_prev_reg;
         SRC_ASYNC: src_tick = (async_cnt_reg == 2'(ASYNC_DIV - 1));
         default: src_tick = 1'b1;
      endcase
   end

   always_comb
   begin
      case (cfg_reg[CF_DIV_LSB +: 2])
         2'h0: div_max = 3'h0;
         2'h1: div_max = 3'h1;
         2'h2: div_max = 3'h3;
         default: div_max = 3'h7;
      endcase
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i || state_reg != ST_CONVERT)
         div_cnt_reg <= 3'h0;
      else if (src_tick)
         div_cnt_reg <= (div_cnt_reg >= div_max) ? 3'h0 : div_cnt_reg + 3'h1;
   end
   assign ck_tick = src_tick && (div_cnt_reg >= div_max);

   // Bus side: wait/stop3 clear conv_active_o for every source but the internal async one
   assign sw_start = wr_i && addr_i == OFS_STATUS_CTRL && wdata_i[4:0] != CHANNEL_OFF;
   assign cfg_write = wr_i && (addr_i == OFS_CMP_CTRL || addr_i == OFS_CONFIG ||
      addr_i == OFS_CMP_HIGH || addr_i == OFS_CMP_LOW);
   assign start = (!cc_reg[CC_TRG_POS] && sw_start) ||
      (cc_reg[CC_TRG_POS] && trg_rise && state_reg == ST_IDLE && !disabled);
   assign steps_needed = (mode == MODE_8) ? 4'd9 : 4'd12;
   assign done = (state_reg == ST_CONVERT) && ck_tick && step_reg == steps_needed;

   // Rounding: add half an LSB of the target width, saturate on overflow
   always_comb
   begin
      rounded = 13'h0;
      result = sar_reg;
      cmp_val = {cvh_reg[3:0], cvl_reg};
      case (mode)
         MODE_10:
         begin
            rounded = {1'b0, sar_reg} + 13'h2;
            result = rounded[12] ? 12'h3FF : {2'h0, rounded[11:2]};
            cmp_val = {2'h0, cvh_reg[1:0], cvl_reg};
         end
         MODE_8:
         begin
            // Trial bits land MSB first, so the nine-bit result sits at the top
            rounded = {4'h0, sar_reg[11:3]} + 13'h1;
            result = rounded[9] ? 12'h0FF : {4'h0, rounded[8:1]};
            cmp_val = {4'h0, cvl_reg};
         end
         default:
         begin
            rounded = {1'b0, sar_reg};
            result = sar_reg;
         end
      endcase
   end
   assign cmp_pass = !cc_reg[CC_CFE_POS] ||
      (cc_reg[CC_CGT_POS] ? (result >= cmp_val) : (result < cmp_val));

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         state_reg <= ST_DISABLED;
         sar_reg <= 12'h0;
         step_reg <= 4'h0;
      end
      // A write naming a real channel leaves the off state, and starts in the same cycle when hardware trigger is off
      else if ((disabled && !sw_start) || (wr_i && addr_i == OFS_STATUS_CTRL && !sw_start))
         state_reg <= ST_DISABLED;
      else if (start || cfg_write)
      begin
         state_reg <= start ? ST_CONVERT : ST_IDLE;
         sar_reg <= 12'h0;
         step_reg <= 4'h0;
      end
      else
         case (state_reg)
            ST_DISABLED: state_reg <= ST_IDLE;
            ST_IDLE: state_reg <= ST_IDLE;
            ST_CONVERT:
               if (done)
               begin
                  step_reg <= 4'h0;
                  sar_reg <= 12'h0;
                  state_reg <= (sc_reg[SC_CONT_POS] || (hold_reg && cmp_pass)) ?
                     ST_CONVERT : ST_IDLE;
               end
               else if (ck_tick)
               begin
                  sar_reg[4'd11 - step_reg] <= cmp_bit_i;
                  step_reg <= step_reg + 4'h1;
               end
            default: state_reg <= ST_DISABLED;
         endcase
   end

   // Trial code presents current bit as one over earlier decisions
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
         sar_trial_o <= 12'h0;
      else if (state_reg == ST_CONVERT && step_reg < 4'd12)
         sar_trial_o <= sar_reg | (12'h800 >> step_reg);
      else
         sar_trial_o <= 12'h0;
   end

   // Reading result high outside 8-bit mode holds off new results until result low is read
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
         hold_reg <= 1'b0;
      else if (rd_i && addr_i == OFS_RESULT_LOW)
         hold_reg <= 1'b0;
      else if (rd_i && addr_i == OFS_RESULT_HIGH && mode != MODE_8)
         hold_reg <= 1'b1;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         rh_reg <= RST_ZERO;
         rl_reg <= RST_ZERO;
      end
      else if (done && cmp_pass && !hold_reg)
      begin
         rh_reg <= (mode == MODE_8) ? RST_ZERO : {4'h0, result[11:8]};
         rl_reg <= result[7:0];
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         sc_reg <= RST_STATUS_CTRL;
         cc_reg <= RST_ZERO;
         cfg_reg <= RST_ZERO;
         cvh_reg <= RST_ZERO;
         cvl_reg <= RST_ZERO;
         pin_low_reg <= RST_ZERO;
         pin_mid_reg <= RST_ZERO;
         pin_high_reg <= RST_ZERO;
      end
      else
      begin
         // Store beats a same-cycle write clearing the flag
         if (done && cmp_pass && !hold_reg)
            sc_reg[SC_FLAG_POS] <= 1'b1;
         else if (wr_i && addr_i == OFS_STATUS_CTRL)
            sc_reg[SC_FLAG_POS] <= 1'b0;
         else if (rd_i && addr_i == OFS_RESULT_LOW)
            sc_reg[SC_FLAG_POS] <= 1'b0;
         if (wr_i)
            case (addr_i)
               OFS_STATUS_CTRL: sc_reg[6:0] <= wdata_i[6:0];
               OFS_CMP_CTRL: cc_reg <= {1'b0, wdata_i[6:4], 4'h0};
               OFS_CONFIG: cfg_reg <= wdata_i;
               OFS_CMP_HIGH: cvh_reg <= {4'h0, wdata_i[3:0]};
               OFS_CMP_LOW: cvl_reg <= wdata_i;
               OFS_PIN_LOW: pin_low_reg <= wdata_i;
               OFS_PIN_MID: pin_mid_reg <= wdata_i;
               OFS_PIN_HIGH: pin_high_reg <= wdata_i;
               default: ;
            endcase
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
         rdata_o <= RST_ZERO;
      else if (rd_i)
         case (addr_i)
            OFS_STATUS_CTRL: rdata_o <= sc_reg;
            OFS_CMP_CTRL: rdata_o <= {cc_reg[7], state_reg == ST_CONVERT, cc_reg[5:0]};
            OFS_CONFIG: rdata_o <= cfg_reg;
            OFS_CMP_HIGH: rdata_o <= cvh_reg;
            OFS_CMP_LOW: rdata_o <= cvl_reg;
            OFS_RESULT_HIGH: rdata_o <= rh_reg;
            OFS_RESULT_LOW: rdata_o <= rl_reg;
            OFS_PIN_LOW: rdata_o <= pin_low_reg;
            OFS_PIN_MID: rdata_o <= pin_mid_reg;
            OFS_PIN_HIGH: rdata_o <= pin_high_reg;
            default: rdata_o <= RST_ZERO;
         endcase
      else
         rdata_o <= RST_ZERO;
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PADS; gi++)
      begin : g_pad
         always_ff @(posedge core_clk_i)
         begin
            if (rst_i)
            begin
               pad_ctrl_o.out_en_n[gi] <= 1'b0;
               pad_ctrl_o.in_en[gi] <= 1'b1;
               pad_ctrl_o.pull_en[gi] <= 1'b1;
               port_read_o[gi] <= 1'b0;
            end
            else
            begin
               pad_ctrl_o.out_en_n[gi] <= pad_disable[gi];
               pad_ctrl_o.in_en[gi] <= !pad_disable[gi];
               pad_ctrl_o.pull_en[gi] <= !pad_disable[gi];
               port_read_o[gi] <= port_in_i[gi] && !pad_disable[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         channel_o <= CHANNEL_OFF;
         conv_active_o <= 1'b0;
         irq_o <= 1'b0;
      end
      else
      begin
         channel_o <= sc_reg[4:0];
         conv_active_o <= (state_reg == ST_CONVERT) && (!low_power_i ||
            cfg_reg[CF_CLK_LSB +: 2] == SRC_ASYNC);
         irq_o <= sc_reg[SC_FLAG_POS] && sc_reg[SC_IEN_POS];
      end
   end

   pad_gate_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      ##1 (pad_ctrl_o.out_en_n == $past(pad_disable)))
      else $error("pad driver not following pin control");
   port_zero_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      ##1 ((port_read_o & $past(pad_disable)) == 24'h0))
      else $error("disabled pad read not zero");
   off_idle_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (disabled && !sw_start) |=> state_reg == ST_DISABLED)
      else $error("converter running with channel off");
   // A restart would drop the step count back to zero
   trig_ignore_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (state_reg == ST_CONVERT && trg_rise && !wr_i && !done) |=>
      (step_reg == $past(step_reg) || step_reg == $past(step_reg) + 4'h1))
      else $error("trigger restarted conversion");
   sequence store_s;
      done && cmp_pass && !hold_reg;
   endsequence
   flag_set_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      store_s |=> sc_reg[SC_FLAG_POS])
      else $error("flag not set after store");
   irq_follow_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      store_s ##1 sc_reg[SC_IEN_POS] |=> irq_o)
      else $error("interrupt missing");
   cmp_block_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (done && !cmp_pass) |=> $stable(rl_reg))
      else $error("result stored on failed compare");
   byte8_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (store_s and (mode == MODE_8)) |=> rh_reg == 8'h00)
      else $error("high result used in 8-bit mode");
endmodule : adc_conversion_control

//--- adc_conversion_control_tb_top.sv
// Self-checking bench for the converter control block: register port, pads, conversions.
// Assumes the comparator input high keeps each trial bit, so a constant 1 gives full scale.
`timescale 1ns/1ps
module adc_conversion_control_tb_top;
   import adc_ctrl_pkg::*;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [7:0] rdata_o;
   logic alternate_clock_i = 1'b0;
   logic hw_trigger_input_i = 1'b0;
   logic cmp_bit_i = 1'b1;
   logic low_power_i = 1'b0;
   logic [23:0] port_in_i = 24'hFFFFFF;
   logic [23:0] port_read_o;
   pad_ctrl_t pad_ctrl_o;
   logic [11:0] sar_trial_o;
   logic [4:0] channel_o;
   logic conv_active_o;
   logic irq_o;
   int miscompares = 0;
   int comparisons = 0;
   int t_div1 [4];
   int t_div8 [4];
   int cyc;
   logic ok;
   logic [7:0] d;
   logic [7:0] hi;
   logic [7:0] lo;
   logic [1:0] modes [3] = '{MODE_12, MODE_10, MODE_8};
   logic [7:0] full_hi [3] = '{8'h0F, 8'h03, 8'h00};
   localparam logic [23:0] MASK = 24'h808103;

   adc_conversion_control DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .alternate_clock_i(alternate_clock_i), .hw_trigger_input_i(hw_trigger_input_i),
      .cmp_bit_i(cmp_bit_i), .low_power_i(low_power_i), .port_in_i(port_in_i),
      .port_read_o(port_read_o), .pad_ctrl_o(pad_ctrl_o), .sar_trial_o(sar_trial_o),
      .channel_o(channel_o), .conv_active_o(conv_active_o), .irq_o(irq_o));

   always #10 core_clk_i = ~core_clk_i;
   // Slow alternate source, well under a quarter of the core rate
   always #110 alternate_clock_i = ~alternate_clock_i;

   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic write_reg(input logic [3:0] a, input logic [7:0] v);
      @(posedge core_clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
   endtask : write_reg

   task automatic read_reg(input logic [3:0] a, output logic [7:0] v);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask : read_reg

   // Starts by writing status/control, then polls the flag with a bounded count
   task automatic convert(input logic [7:0] sc, output int cycles, output logic done);
      logic [7:0] s;
      write_reg(OFS_STATUS_CTRL, sc);
      cycles = 0;
      done = 1'b0;
      repeat (3000)
      begin
         if (!done)
         begin
            read_reg(OFS_STATUS_CTRL, s);
            cycles += 2;
            done = (s[SC_FLAG_POS] === 1'b1);
         end
      end
   endtask : convert

   task automatic read_result();
      read_reg(OFS_RESULT_HIGH, hi);
      read_reg(OFS_RESULT_LOW, lo);
   endtask : read_result

   task automatic give_verdict();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   initial
   begin
      // Longest path is the refused compare poll, about 6000 cycles; all tests well under this
      repeat (60000) @(posedge core_clk_i);
      miscompares++;
      give_verdict();
   end

   initial
   begin
      repeat (5) @(posedge core_clk_i);
      rst_i <= 1'b0;
      read_reg(OFS_PIN_LOW, d);
      check("pin low reset", d, 8'h00);
      read_reg(OFS_PIN_HIGH, d);
      check("pin high reset", d, 8'h00);
      check("out_en_n reset", pad_ctrl_o.out_en_n, 24'h000000);
      check("in_en reset", pad_ctrl_o.in_en, 24'hFFFFFF);
      check("channel reset", channel_o, 5'h1F);
      check("active reset", conv_active_o, 1'b0);
      read_reg(OFS_CONFIG, d);
      check("clock source reset", d[1:0], SRC_BUS);
      read_reg(4'hF, d);
      check("unmapped read", d, 8'h00);
      write_reg(OFS_PIN_LOW, 8'h03);
      write_reg(OFS_PIN_MID, 8'h81);
      write_reg(OFS_PIN_HIGH, 8'h80);
      read_reg(OFS_PIN_MID, d);
      check("pin mid readback", d, 8'h81);
      repeat (2) @(posedge core_clk_i);
      #1 check("driver off", pad_ctrl_o.out_en_n, MASK);
      check("input buffer", pad_ctrl_o.in_en, ~MASK);
      check("pull-up", pad_ctrl_o.pull_en, ~MASK);
      check("port read", port_read_o, ~MASK);
      // Every mode, comparator stuck high then low
      for (int m = 0; m < 3; m++)
      begin
         for (int b = 1; b >= 0; b--)
         begin
            cmp_bit_i <= b[0];
            write_reg(OFS_CONFIG, {3'b000, 1'b0, modes[m], SRC_BUS});
            convert(8'h05, cyc, ok);
            check("mode done", ok, 1'b1);
            check("channel", channel_o, 5'h05);
            repeat (2) @(posedge core_clk_i);
            #1 check("idle after done", conv_active_o, 1'b0);
            check("trial idle", sar_trial_o, 12'h000);
            read_result();
            check("result high", hi, b ? full_hi[m] : 8'h00);
            check("result low", lo, b ? 8'hFF : 8'h00);
         end
      end
      cmp_bit_i <= 1'b1;
      write_reg(OFS_CONFIG, {3'b000, 1'b0, MODE_12, SRC_BUS});
      convert(8'h40, cyc, ok);
      repeat (2) @(posedge core_clk_i);
      #1 check("irq raised", irq_o, 1'b1);
      read_result();
      repeat (2) @(posedge core_clk_i);
      #1 check("irq cleared", irq_o, 1'b0);
      convert(8'h00, cyc, ok);
      repeat (2) @(posedge core_clk_i);
      #1 check("irq masked", irq_o, 1'b0);
      // Each source at divide 1 and divide 8
      for (int s = 0; s < 4; s++)
      begin
         write_reg(OFS_CONFIG, {1'b0, 2'b00, 1'b0, MODE_12, s[1:0]});
         convert(8'h00, t_div1[s], ok);
         check("source div1 done", ok, 1'b1);
         write_reg(OFS_CONFIG, {1'b0, 2'b11, 1'b0, MODE_12, s[1:0]});
         convert(8'h00, t_div8[s], ok);
         check("source div8 done", ok, 1'b1);
         check("divide slows", t_div8[s] > t_div1[s], 1'b1);
      end
      check("half bus slower", t_div8[1] > t_div8[0], 1'b1);
      low_power_i <= 1'b1;
      write_reg(OFS_CONFIG, {3'b000, 1'b0, MODE_12, SRC_ASYNC});
      convert(8'h00, cyc, ok);
      check("async in low power", ok, 1'b1);
      low_power_i <= 1'b0;
      // Compare: full-scale result against 0x800, then 8-bit against 0x80
      write_reg(OFS_CONFIG, {3'b000, 1'b0, MODE_12, SRC_BUS});
      write_reg(OFS_CMP_HIGH, 8'h08);
      write_reg(OFS_CMP_LOW, 8'h00);
      write_reg(OFS_CMP_CTRL, 8'h30);
      convert(8'h00, cyc, ok);
      check("compare ge", ok, 1'b1);
      write_reg(OFS_CMP_CTRL, 8'h20);
      convert(8'h00, cyc, ok);
      check("compare lt false", ok, 1'b0);
      write_reg(OFS_CONFIG, {3'b000, 1'b0, MODE_8, SRC_BUS});
      write_reg(OFS_CMP_LOW, 8'h80);
      write_reg(OFS_CMP_CTRL, 8'h30);
      convert(8'h00, cyc, ok);
      check("compare 8-bit", ok, 1'b1);
      // Hardware trigger with a second edge inside the slow conversion
      write_reg(OFS_CONFIG, {1'b0, 2'b11, 1'b0, MODE_12, SRC_BUS});
      // Trigger enabled first, so the status write below must not start anything
      write_reg(OFS_CMP_CTRL, 8'h40);
      write_reg(OFS_STATUS_CTRL, 8'h00);
      read_result();
      repeat (4) @(posedge core_clk_i);
      #1 check("no sw start", conv_active_o, 1'b0);
      for (int p = 0; p < 2; p++)
      begin
         hw_trigger_input_i <= 1'b1;
         repeat (6) @(posedge core_clk_i);
         hw_trigger_input_i <= 1'b0;
         repeat (6) @(posedge core_clk_i);
      end
      #1 check("trigger started", conv_active_o, 1'b1);
      // Two trial bits kept by now; a restart on the second edge would show step zero
      check("trial after edges", sar_trial_o, 12'hE00);
      // First conversion ends near 108 cycles after the first edge, a restarted one near 120
      repeat (86) @(posedge core_clk_i);
      read_reg(OFS_STATUS_CTRL, d);
      check("trigger done", d[SC_FLAG_POS], 1'b1);
      read_result();
      repeat (300) @(posedge core_clk_i);
      read_reg(OFS_STATUS_CTRL, d);
      check("second edge ignored", d[SC_FLAG_POS], 1'b0);
      write_reg(OFS_CMP_CTRL, 8'h00);
      write_reg(OFS_STATUS_CTRL, 8'h1F);
      repeat (2) @(posedge core_clk_i);
      #1 check("channel off", channel_o, 5'h1F);
      check("disabled", conv_active_o, 1'b0);
      give_verdict();
   end
endmodule : adc_conversion_control_tb_top
